// [design/reset_cause_status_and_init.sv]
// Reset cause flags, restart address and register initialization by reset class
//
// Overview of operation
// - Plain registers unknown at power-on, kept otherwise
// - Defined registers load value per reset kind
// - Watchdog wake keeps most registers
// - Power-on: PC zero, set instr/timeout/power-down flags
// - Reset instruction: PC zero, clear instruction flag
// - Brown-out: PC zero, set instr/timeout/power-down flags
// - Master clear in run: set timeout
// - Master clear idle/sleep: set timeout, clear power-down
// - Watchdog in full/run: PC zero, clear TO
// - Master clear full power: flags unchanged
// - Stack full with enable: reset, flag
// - Stack underflow with enable: reset, flag
// - Underflow without enable: flag only, PC zero
// - Watchdog idle/sleep: wake, PC+2, clear timeout/power-down
// - Interrupt wake: clear PD; PC+2 when its priority is not enabled
// - Enabled interrupt wake loads vector address
// - Enabled interrupt wake pushes PC
// - Software brown-out enable reset behaviour
// - Three initialization classes distinguished
// - Wake-up signals interrupt flag update
// - Port bit 6 only when oscillator frees it
// - Unimplemented bits read zero
`timescale 1ns/1ps
module reset_cause_status_and_init
  import reset_cause_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                srst_i,
  input  wire logic                ce_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rdata_o,
  input  wire logic                master_clear_pin_n_i,
  input  wire logic                port_a_bit6_input_i,
  input  wire reset_events_t       events_i,
  input  wire reset_config_t       config_i,
  input  wire power_mode_t         power_mode_i,
  input  wire logic                high_priority_global_int_enable_i,
  input  wire logic                low_priority_global_int_enable_i,
  input  wire logic [PC_W-1:0]     pc_i,
  output logic                     core_restart_o,
  output logic                     pc_load_o,
  output logic      [PC_W-1:0]     pc_value_o,
  output init_class_t              init_class_o,
  output logic      [1:0]          wake_int_flag_o,
  output logic                     brownout_enable_o,
  output logic      [PC_W-1:0]     top_of_stack_o,
  output logic      [SP_W-1:0]     stack_pointer_o,
  output logic                     port_a_bit6_latch_o,
  output logic                     port_a_bit6_oe_o
);

  function automatic logic low_power(input power_mode_t m);
    low_power = (m == PM_IDLE) || (m == PM_SLEEP);
  endfunction

  function automatic cause_t decode(
    input reset_events_t e,
    input logic          pin_clr,
    input power_mode_t   m,
    input logic          stv
  );
    decode = C_NONE;
    if (e.brownout) begin
      decode = C_BOR;
    end else if (pin_clr) begin
      if (low_power(m)) begin
        decode = C_PIN_IDLE;
      end else if (m == PM_RUN) begin
        decode = C_PIN_RUN;
      end else begin
        decode = C_PIN_FULL;
      end
    end else if (e.wdt_timeout) begin
      decode = low_power(m) ? C_WDT_WAKE : C_WDT_RST;
    end else if (e.reset_instr) begin
      decode = C_RSTI;
    end else if (e.stack_full && stv) begin
      decode = C_STK_FULL;
    end else if (e.stack_underflow) begin
      decode = stv ? C_STK_UNF : C_STK_ERR;
    end else if (e.int_wake && (m != PM_FULL)) begin
      decode = C_INT_WAKE;
    end
  endfunction

  logic              pin_clr_s1;
  logic              pin_clr_s2;
  logic              pin_clr_s3;
  logic              p6_s1;
  logic              p6_s2;
  logic              pin_clr_fall;
  cause_t            cause;
  init_class_t       cls;
  logic              vec_en;
  logic [PC_W-1:0]   vec_addr;
  logic              sw_bor_mode;
  logic              wr_cause;
  logic              wr_stack;

  logic              sw_brownout_enable;
  logic              reset_instruction_flag;
  logic              timeout_flag;
  logic              power_down_flag;
  logic              power_on_flag;
  logic              brownout_flag;
  logic              stack_full_flag;
  logic              stack_underflow_flag;
  logic [SP_W-1:0]   stack_ptr;
  logic [PC_W-1:0]   tos;
  logic              p6_latch;
  logic              p6_dir;
  logic [DATA_W-1:0] scratch;
  logic [DATA_W-1:0] init_reg;
  logic [DATA_W-1:0] next_rdata;

  // Pin synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_clr_s1 <= 1'b1;
      pin_clr_s2 <= 1'b1;
      pin_clr_s3 <= 1'b1;
      p6_s1   <= 1'b0;
      p6_s2   <= 1'b0;
    end else if (ce_i) begin
      pin_clr_s1 <= master_clear_pin_n_i;
      pin_clr_s2 <= pin_clr_s1;
      pin_clr_s3 <= pin_clr_s2;
      p6_s1   <= port_a_bit6_input_i;
      p6_s2   <= p6_s1;
    end
  end

  assign pin_clr_fall = pin_clr_s3 && !pin_clr_s2;
  assign sw_bor_mode = (config_i.brownout_mode_config == BOR_MODE_SW);
  assign wr_cause    = wr_i && (addr_i == ADDR_CAUSE);
  assign wr_stack    = wr_i && (addr_i == ADDR_STACK);

  always_comb begin
    cause = decode(events_i, pin_clr_fall, power_mode_i,
                   config_i.stack_error_reset_enable);
  end

  // Class of initialization for each cause
  always_comb begin
    unique case (cause)
      C_NONE:      cls = CLS_NONE;
      C_BOR:       cls = CLS_COLD;
      C_STK_ERR:   cls = CLS_NONE;
      C_WDT_WAKE,
      C_INT_WAKE:  cls = CLS_WAKE;
      C_RSTI,
      C_PIN_RUN,
      C_PIN_IDLE,
      C_PIN_FULL,
      C_WDT_RST,
      C_STK_FULL,
      C_STK_UNF:   cls = CLS_WARM;
      default:     cls = CLS_NONE;
    endcase
  end

  // Vector selection for an enabled interrupt wake
  always_comb begin
    vec_en   = 1'b0;
    vec_addr = PC_RESET;
    if (events_i.int_high_prio && high_priority_global_int_enable_i) begin
      vec_en   = 1'b1;
      vec_addr = VEC_HIGH;
    end else if (!events_i.int_high_prio && low_priority_global_int_enable_i) begin
      vec_en   = 1'b1;
      vec_addr = VEC_LOW;
    end
  end

  // Reset status flags
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reset_instruction_flag <= 1'b1;
      timeout_flag           <= 1'b1;
      power_down_flag        <= 1'b1;
      power_on_flag          <= 1'b0;
      brownout_flag          <= 1'b0;
    end else if (ce_i) begin
      if (wr_cause) begin
        reset_instruction_flag <= wdata_i[RSTI_BIT];
        power_on_flag          <= wdata_i[POR_BIT];
        brownout_flag          <= wdata_i[BOR_BIT];
      end
      unique case (cause)
        C_RSTI: begin
          reset_instruction_flag <= 1'b0;
        end
        C_BOR: begin
          reset_instruction_flag <= 1'b1;
          timeout_flag           <= 1'b1;
          power_down_flag        <= 1'b1;
          brownout_flag          <= 1'b0;
        end
        C_PIN_RUN: begin
          timeout_flag <= 1'b1;
        end
        C_PIN_IDLE: begin
          timeout_flag    <= 1'b1;
          power_down_flag <= 1'b0;
        end
        C_WDT_RST: begin
          timeout_flag <= 1'b0;
        end
        C_WDT_WAKE: begin
          timeout_flag    <= 1'b0;
          power_down_flag <= 1'b0;
        end
        C_INT_WAKE: begin
          power_down_flag <= 1'b0;
        end
        C_NONE, C_PIN_FULL, C_STK_FULL, C_STK_UNF, C_STK_ERR: begin
        end
        default: begin
        end
      endcase
    end
  end

  // Software brown-out enable
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sw_brownout_enable <= 1'b1;
    end else if (ce_i) begin
      if (cls == CLS_COLD || cls == CLS_WARM) begin
        sw_brownout_enable <= sw_brownout_enable && sw_bor_mode;
      end else if (wr_cause) begin
        sw_brownout_enable <= wdata_i[SWBO_BIT];
      end
    end
  end

  // Stack flags, pointer and top of stack
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stack_full_flag      <= 1'b0;
      stack_underflow_flag <= 1'b0;
      stack_ptr            <= SP_RESET;
      tos                  <= PC_RESET;
    end else if (ce_i) begin
      if (wr_stack) begin
        stack_full_flag      <= wdata_i[FULL_BIT];
        stack_underflow_flag <= wdata_i[UNF_BIT];
        stack_ptr            <= wdata_i[SP_W-1:0];
      end
      if (cause == C_STK_FULL) begin
        stack_full_flag <= 1'b1;
      end
      if (cause == C_STK_UNF || cause == C_STK_ERR) begin
        stack_underflow_flag <= 1'b1;
      end
      if (cls == CLS_COLD || cls == CLS_WARM) begin
        stack_ptr <= SP_RESET;
        tos       <= PC_RESET;
      end else if (cause == C_INT_WAKE && vec_en) begin
        tos       <= pc_i;
        stack_ptr <= SP_W'(stack_ptr + SP_STEP);
      end
    end
  end

  // Register with a defined value per reset kind
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      init_reg <= INIT_COLD;
    end else if (ce_i) begin
      if (cls == CLS_COLD) begin
        init_reg <= INIT_COLD;
      end else if (cls == CLS_WARM) begin
        init_reg <= INIT_WARM;
      end else if (wr_i && addr_i == ADDR_INIT) begin
        init_reg <= wdata_i;
      end
    end
  end

  // Plain register with no defined reset value
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && wr_i && addr_i == ADDR_SCRAT) begin
      scratch <= wdata_i;
    end
  end

  // Port bit 6 latch and direction
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      p6_latch <= LAT6_RST;
      p6_dir   <= DIR6_RST;
    end else if (ce_i) begin
      if (cls == CLS_COLD || cls == CLS_WARM) begin
        p6_latch <= LAT6_RST;
        p6_dir   <= DIR6_RST;
      end else if (wr_i && addr_i == ADDR_PORTA6 && config_i.osc_frees_pin) begin
        p6_latch <= wdata_i[P6_LAT_BIT];
        p6_dir   <= wdata_i[P6_DIR_BIT];
      end
    end
  end

  // Restart and program counter control
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      core_restart_o  <= 1'b1;
      pc_load_o       <= 1'b1;
      pc_value_o      <= PC_RESET;
      init_class_o    <= CLS_COLD;
      wake_int_flag_o <= 2'h0;
    end else if (ce_i) begin
      core_restart_o  <= (cls == CLS_COLD) || (cls == CLS_WARM);
      pc_load_o       <= (cause != C_NONE);
      init_class_o    <= cls;
      wake_int_flag_o <= {cause == C_WDT_WAKE, cause == C_INT_WAKE};
      if (cause == C_WDT_WAKE) begin
        pc_value_o <= PC_W'(pc_i + PC_STEP);
      end else if (cause == C_INT_WAKE) begin
        pc_value_o <= vec_en ? vec_addr : PC_W'(pc_i + PC_STEP);
      end else if (cause != C_NONE) begin
        pc_value_o <= PC_RESET;
      end
    end
  end

  // Outputs that mirror state
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      brownout_enable_o   <= 1'b0;
      top_of_stack_o      <= PC_RESET;
      stack_pointer_o     <= SP_RESET;
      port_a_bit6_latch_o <= 1'b0;
      port_a_bit6_oe_o    <= 1'b0;
    end else if (ce_i) begin
      brownout_enable_o <= (config_i.brownout_mode_config == BOR_MODE_HW) ||
                           (config_i.brownout_mode_config == BOR_MODE_NOSLP &&
                            power_mode_i != PM_SLEEP) ||
                           (sw_bor_mode && sw_brownout_enable);
      top_of_stack_o      <= tos;
      stack_pointer_o     <= stack_ptr;
      port_a_bit6_latch_o <= p6_latch && config_i.osc_frees_pin;
      port_a_bit6_oe_o    <= !p6_dir && config_i.osc_frees_pin;
    end
  end

  // Read multiplexer
  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CAUSE: begin
          next_rdata[SWBO_BIT]   = sw_brownout_enable && sw_bor_mode;
          next_rdata[RSTI_BIT]   = reset_instruction_flag;
          next_rdata[TMO_BIT]    = timeout_flag;
          next_rdata[PDN_BIT]    = power_down_flag;
          next_rdata[POR_BIT]    = power_on_flag;
          next_rdata[BOR_BIT]    = brownout_flag;
        end
        ADDR_STACK: begin
          next_rdata[FULL_BIT]   = stack_full_flag;
          next_rdata[UNF_BIT]    = stack_underflow_flag;
          next_rdata[SP_W-1:0]   = stack_ptr;
        end
        ADDR_TOS_L:  next_rdata = tos[DATA_W-1:0];
        ADDR_TOS_H:  next_rdata = tos[TOS_H_LSB +: DATA_W];
        ADDR_TOS_U:  next_rdata[PC_W-TOS_U_LSB-1:0] = tos[PC_W-1:TOS_U_LSB];
        ADDR_PORTA6: begin
          if (config_i.osc_frees_pin) begin
            next_rdata[P6_IN_BIT]  = p6_s2;
            next_rdata[P6_LAT_BIT] = p6_latch;
            next_rdata[P6_DIR_BIT] = p6_dir;
          end
        end
        ADDR_SCRAT:  next_rdata = scratch;
        ADDR_INIT:   next_rdata = init_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule // reset_cause_status_and_init

// [design/reset_cause_pkg.sv]
// Constants, types and carriers for the reset cause and initialization block
package reset_cause_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PC_W   = 21;
  localparam int SP_W   = 5;

  localparam logic [ADDR_W-1:0] ADDR_CAUSE  = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STACK  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_TOS_L  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_TOS_H  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_TOS_U  = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_PORTA6 = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_SCRAT  = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_INIT   = 3'h7;

  localparam int SWBO_BIT   = 6;
  localparam int RSTI_BIT   = 4;
  localparam int TMO_BIT    = 3;
  localparam int PDN_BIT    = 2;
  localparam int POR_BIT    = 1;
  localparam int BOR_BIT    = 0;
  localparam int FULL_BIT   = 7;
  localparam int UNF_BIT    = 6;
  localparam int P6_IN_BIT  = 0;
  localparam int P6_LAT_BIT = 1;
  localparam int P6_DIR_BIT = 2;
  localparam int TOS_H_LSB  = 8;
  localparam int TOS_U_LSB  = 16;

  localparam logic [PC_W-1:0]   PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0]   VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0]   VEC_LOW  = 21'h000018;
  localparam logic [PC_W-1:0]   PC_STEP  = 21'h000002;
  localparam logic [SP_W-1:0]   SP_RESET = 5'h00;
  localparam logic [SP_W-1:0]   SP_STEP  = 5'h01;
  localparam logic [1:0]        BOR_MODE_SW    = 2'h1;
  localparam logic [1:0]        BOR_MODE_NOSLP = 2'h2;
  localparam logic [1:0]        BOR_MODE_HW    = 2'h3;
  localparam logic [DATA_W-1:0] INIT_COLD = 8'h00;
  localparam logic [DATA_W-1:0] INIT_WARM = 8'h01;
  localparam logic              LAT6_RST  = 1'b0;
  localparam logic              DIR6_RST  = 1'b1;

  typedef enum logic [1:0] {
    PM_FULL  = 2'b00,
    PM_RUN   = 2'b01,
    PM_IDLE  = 2'b10,
    PM_SLEEP = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    CLS_NONE = 2'b00,
    CLS_COLD = 2'b01,
    CLS_WARM = 2'b10,
    CLS_WAKE = 2'b11
  } init_class_t;

  typedef enum logic [3:0] {
    C_NONE      = 4'b0000,
    C_BOR       = 4'b0001,
    C_RSTI      = 4'b0010,
    C_PIN_RUN   = 4'b0011,
    C_PIN_IDLE  = 4'b0100,
    C_PIN_FULL  = 4'b0101,
    C_WDT_RST   = 4'b0110,
    C_WDT_WAKE  = 4'b0111,
    C_STK_FULL  = 4'b1000,
    C_STK_UNF   = 4'b1001,
    C_STK_ERR   = 4'b1010,
    C_INT_WAKE  = 4'b1011
  } cause_t;

  typedef struct packed {
    logic brownout;
    logic reset_instr;
    logic wdt_timeout;
    logic stack_full;
    logic stack_underflow;
    logic int_wake;
    logic int_high_prio;
  } reset_events_t;

  typedef struct packed {
    logic [1:0] brownout_mode_config;
    logic       stack_error_reset_enable;
    logic       osc_frees_pin;
  } reset_config_t;
endpackage

// [bench/core_model.sv]
// Core model: fetch address that follows each load from the reset block
`timescale 1ns/1ps
module core_model
  import reset_cause_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            load_i,
  input  wire logic [PC_W-1:0] target_i,
  output logic      [PC_W-1:0] pc_o
);
  // Jumps on restart, wake or underflow error, else steps one instruction
  always_ff @(posedge ref_clk_i) begin
    if (load_i) begin
      pc_o <= target_i;
    end else begin
      pc_o <= pc_o + PC_STEP;
    end
  end
endmodule // core_model

// [bench/reset_cause_chk.sv]
// Checker for restart, class, wake and stack outputs
`timescale 1ns/1ps
module reset_cause_chk
  import reset_cause_pkg::*;
(
  input wire logic            ref_clk_i,
  input wire logic            srst_i,
  input wire logic            ce_i,
  input wire logic            wr_i,
  input wire logic            master_clear_pin_n_i,
  input wire reset_events_t   events_i,
  input wire reset_config_t   config_i,
  input wire power_mode_t     power_mode_i,
  input wire logic            high_priority_global_int_enable_i,
  input wire logic            low_priority_global_int_enable_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic            core_restart_o,
  input wire logic            pc_load_o,
  input wire logic [PC_W-1:0] pc_value_o,
  input wire init_class_t     init_class_o,
  input wire logic [1:0]      wake_int_flag_o,
  input wire logic [PC_W-1:0] top_of_stack_o,
  input wire logic [SP_W-1:0] stack_pointer_o,
  input wire logic            port_a_bit6_oe_o
);
  logic [2:0] hi_cnt;
  logic       quiet;
  logic       int_only;
  logic       int_en;
  // Pin released long enough that no pin event is pending
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !master_clear_pin_n_i) begin
      hi_cnt <= 3'h0;
    end else if (hi_cnt != 3'h7) begin
      hi_cnt <= hi_cnt + 3'h1;
    end
  end
  assign quiet = ce_i && (hi_cnt == 3'h7);
  assign int_only = quiet && (events_i[6:2] == 5'h00) && events_i.int_wake
                    && (power_mode_i != PM_FULL);
  assign int_en = events_i.int_high_prio ? high_priority_global_int_enable_i
                                         : low_priority_global_int_enable_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  AST_COLD_INIT: assert property ($fell(srst_i) |-> core_restart_o && pc_load_o
    && pc_value_o == PC_RESET && init_class_o == CLS_COLD) else $error("cold init wrong");
  AST_RSTI: assert property (quiet && events_i[6:4] == 3'b010 |=> core_restart_o
    && pc_value_o == PC_RESET && init_class_o == CLS_WARM) else $error("reset instr wrong");
  AST_WDT_RST: assert property (quiet && events_i[6:4] == 3'b001 && !power_mode_i[1]
    |=> core_restart_o && pc_value_o == PC_RESET) else $error("watchdog reset wrong");
  AST_WDT_WAKE: assert property (quiet && events_i[6:4] == 3'b001 && power_mode_i[1]
    |=> !core_restart_o && pc_value_o == $past(pc_i) + PC_STEP && init_class_o == CLS_WAKE
    && wake_int_flag_o == 2'b10) else $error("watchdog wake wrong");
  AST_INT_VEC: assert property (int_only && int_en |=> pc_load_o
    && pc_value_o == ($past(events_i.int_high_prio) ? VEC_HIGH : VEC_LOW))
    else $error("vector wrong");
  AST_INT_NEXT: assert property (int_only && !int_en |=> !core_restart_o
    && pc_value_o == $past(pc_i) + PC_STEP && wake_int_flag_o == 2'b01)
    else $error("interrupt wake wrong");
  AST_INT_PUSH: assert property (int_only && int_en && !wr_i |-> ##2
    top_of_stack_o == $past(pc_i, 2) && stack_pointer_o == $past(stack_pointer_o) + SP_STEP)
    else $error("stack push wrong");
  AST_UNF_ERR: assert property (quiet && events_i[6:2] == 5'h01
    && !config_i.stack_error_reset_enable |=> pc_load_o && !core_restart_o
    && pc_value_o == PC_RESET && init_class_o == CLS_NONE) else $error("underflow wrong");
  AST_P6_OFF: assert property (!config_i.osc_frees_pin
    && !$past(config_i.osc_frees_pin) |-> !port_a_bit6_oe_o) else $error("port6 oe wrong");
  COV_WDT_WAKE: cover property (quiet && events_i.wdt_timeout && power_mode_i[1]);
  COV_INT_VEC: cover property (int_only && int_en);
  COV_UNF_ERR: cover property (quiet && events_i.stack_underflow
    && !config_i.stack_error_reset_enable);
endmodule // reset_cause_chk

bind reset_cause_status_and_init reset_cause_chk reset_cause_chk_i (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .wr_i(wr_i),
  .master_clear_pin_n_i(master_clear_pin_n_i), .events_i(events_i), .config_i(config_i),
  .power_mode_i(power_mode_i),
  .high_priority_global_int_enable_i(high_priority_global_int_enable_i),
  .low_priority_global_int_enable_i(low_priority_global_int_enable_i), .pc_i(pc_i),
  .core_restart_o(core_restart_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
  .init_class_o(init_class_o), .wake_int_flag_o(wake_int_flag_o),
  .top_of_stack_o(top_of_stack_o), .stack_pointer_o(stack_pointer_o),
  .port_a_bit6_oe_o(port_a_bit6_oe_o));

// [bench/reset_cause_status_and_init_tb.sv]
// Self-checking testbench for the reset cause and initialization block
`timescale 1ns/1ps
module reset_cause_status_and_init_tb;
  import reset_cause_pkg::*;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              clr_pin_n = 1'b1;
  logic              ce = 1'b1;
  logic              p6 = 1'b0;
  logic              gh = 1'b0;
  logic              gl = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] fl;
  logic [DATA_W-1:0] eini;
  reset_events_t     ev = '0;
  reset_config_t     cfg = '{2'h1, 1'b1, 1'b1};
  power_mode_t       mode = PM_FULL;
  power_mode_t       m;
  init_class_t       cls;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   pcv;
  logic [PC_W-1:0]   tos;
  logic [PC_W-1:0]   p;
  logic [PC_W-1:0]   epc;
  logic [SP_W-1:0]   sp;
  logic [SP_W-1:0]   esp;
  logic [1:0]        wk;
  logic              rst_o, load_o, bo_en, lat6, oe6, ful, unf, stv, hp;
  int                k;
  int                n_fail = 0;
  int                compares = 0;

  always #12.5ns clk = ~clk;

  reset_cause_status_and_init reset_cause_status_and_init_i (
    .ref_clk_i(clk), .srst_i(srst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .master_clear_pin_n_i(clr_pin_n), .port_a_bit6_input_i(p6),
    .events_i(ev), .config_i(cfg), .power_mode_i(mode),
    .high_priority_global_int_enable_i(gh), .low_priority_global_int_enable_i(gl),
    .pc_i(pc), .core_restart_o(rst_o), .pc_load_o(load_o), .pc_value_o(pcv),
    .init_class_o(cls), .wake_int_flag_o(wk), .brownout_enable_o(bo_en),
    .top_of_stack_o(tos), .stack_pointer_o(sp), .port_a_bit6_latch_o(lat6),
    .port_a_bit6_oe_o(oe6));
  core_model core_model_i (.ref_clk_i(clk), .load_i(load_o), .target_i(pcv), .pc_o(pc));

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (e !== s) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic wreg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  // Pin event or one-cycle event pulse; for a pulse returns the address seen at the event edge, zero for the pin
  task automatic fire(int kk, logic h, output logic [PC_W-1:0] pe);
    pe = '0;
    if (kk == 2) begin
      @(posedge clk);
      clr_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      clr_pin_n <= 1'b1;
    end else begin
      @(posedge clk);
      ev <= reset_events_t'((7'h40 >> ((kk < 2) ? kk : kk - 1)) | {6'h00, h});
      @(posedge clk);
      pe = pc;
      ev <= '0;
    end
  endtask

  function automatic void predict(int kk, power_mode_t mm, logic s, logic h, logic ge_h,
                                  logic ge_l, logic [PC_W-1:0] pe);
    eini = 8'ha5;
    esp = SP_RESET;
    case (kk)
      0: begin
        fl = (fl & 8'he2) | 8'h1c;
        epc = PC_RESET;
        eini = INIT_COLD;
      end
      1: begin
        fl[RSTI_BIT] = 1'b0;
        epc = PC_RESET;
        eini = INIT_WARM;
      end
      2: begin
        fl[TMO_BIT] = fl[TMO_BIT] | (mm != PM_FULL);
        fl[PDN_BIT] = fl[PDN_BIT] & !mm[1];
        epc = PC_RESET;
        eini = INIT_WARM;
      end
      3: begin
        fl[TMO_BIT] = 1'b0;
        fl[PDN_BIT] = fl[PDN_BIT] & !mm[1];
        epc = mm[1] ? pe + PC_STEP : PC_RESET;
        eini = mm[1] ? eini : INIT_WARM;
      end
      4, 5: begin
        ful = ful | (s && kk == 4);
        unf = unf | (kk == 5);
        epc = (s || kk == 5) ? PC_RESET : epc;
        eini = s ? INIT_WARM : eini;
      end
      default: if (mm != PM_FULL) begin
        fl[PDN_BIT] = 1'b0;
        esp = (h ? ge_h : ge_l) ? SP_STEP : SP_RESET;
        epc = (h ? ge_h : ge_l) ? (h ? VEC_HIGH : VEC_LOW) : pe + PC_STEP;
      end
    endcase
  endfunction

  task automatic complete_run();
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200us;
    n_fail++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hb9f6));
    p6 <= 1'($urandom);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    fl = 8'h5c;
    ful = 1'b0;
    unf = 1'b0;
    rreg(ADDR_CAUSE, d); chk("cause", fl, d);
    chk("bo_en", 1'b1, bo_en);
    rreg(ADDR_STACK, d); chk("stack", 8'h00, d);
    rreg(ADDR_INIT, d); chk("init", INIT_COLD, d);
    rreg(ADDR_PORTA6, d); chk("port6", {5'h00, DIR6_RST, LAT6_RST, p6}, d);
    wreg(ADDR_PORTA6, 8'h02);
    rreg(ADDR_PORTA6, d); chk("port6", {6'h00, 1'b1, p6}, d);
    chk("oe6", 1'b1, oe6);
    chk("lat6", 1'b1, lat6);
    cfg.osc_frees_pin <= 1'b0;
    rreg(ADDR_PORTA6, d); chk("port6", 8'h00, d);
    chk("oe6", 1'b0, oe6);
    wreg(ADDR_CAUSE, 8'h5e);
    fl = 8'h5e;
    wreg(ADDR_SCRAT, 8'h3c);
    for (int i = 0; i < 80; i++) begin
      k = (i < 28) ? i % 7 : int'($urandom_range(6, 0));
      m = power_mode_t'((i < 28) ? i / 7 : $urandom_range(3, 0));
      stv = 1'($urandom);
      hp = 1'($urandom);
      d = 8'($urandom);
      wreg(ADDR_CAUSE, d);
      fl = (fl & 8'h0c) | (d & 8'h53);
      d = 8'($urandom) & 8'hc0;
      wreg(ADDR_STACK, d);
      {ful, unf} = d[7:6];
      wreg(ADDR_INIT, 8'ha5);
      mode <= m;
      cfg.stack_error_reset_enable <= stv;
      gh <= 1'($urandom);
      gl <= 1'($urandom);
      fire(k, hp, p);
      predict(k, m, stv, hp, gh, gl, p);
      repeat (6) @(posedge clk);
      chk("pc", epc, pcv);
      if (esp == SP_STEP) chk("tos", p, tos);
      rreg(ADDR_CAUSE, d); chk("cause", fl, d);
      rreg(ADDR_STACK, d); chk("stack", {ful, unf, 1'b0, esp}, d);
      rreg(ADDR_INIT, d); chk("init", eini, d);
    end
    ce <= 1'b0;
    wreg(ADDR_SCRAT, 8'hc3);
    ce <= 1'b1;
    rreg(ADDR_SCRAT, d); chk("scratch", 8'h3c, d);
    wreg(ADDR_CAUSE, 8'h40);
    fl = (fl & 8'h0c) | 8'h40;
    cfg.brownout_mode_config <= BOR_MODE_HW;
    fire(1, 1'b0, p);
    cfg.brownout_mode_config <= BOR_MODE_SW;
    fl = fl & 8'h0c;
    rreg(ADDR_CAUSE, d); chk("cause", fl, d);
    chk("bo_en", 1'b0, bo_en);
    complete_run();
  end
endmodule // reset_cause_status_and_init_tb
